// >>> logic/lfs_status_flags.sv
`timescale 1ns/1ps
// Contract
// - Overtemperature sets thermal flag, disables, sets disabled
// - Ninth-clock read sample clears thermal if gone
// - Undervoltage sets flag, locks output, sets disabled
// - Ninth-clock read sample clears undervoltage if gone
// - Output stays off until host enable write
// - Tone flag set when tone enabled and present
// - Tone flag clear when tone generation disabled
// - Secondary register uses only bit two
// - Disabled flag set at reset/fault/disabling write, cleared by enabling write while no fault flag is latched
// - Disabled flag rising never raises interrupt
module lfs_status_flags
  import lfs_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Analog fault and tone sense (asynchronous)
  input wire logic overtemp_i,
  input wire logic undervolt_i,
  input wire logic tone_sense_i,
  // From serial engine and control registers (same clock)
  input wire logic read_ninth_rise_i,
  input wire logic write_end_i,
  input wire logic out_enable_bit_i,
  input wire logic tone_enable_i,
  // Status bytes and controls
  output logic [STAT_W-1:0] fault_status_primary_o,
  output logic [STAT_W-1:0] tone_status_secondary_o,
  output logic output_on_o,
  output logic fault_irq_o
);

  // Reset images of the status bytes, built from the flag resets
  localparam logic [STAT_W-1:0] PRIM_RST = (STAT_W'(OUT_OFF_RST) << OUT_OFF_BIT)
    | (STAT_W'(THERMAL_RST) << THERMAL_BIT)
    | (STAT_W'(UV_RST) << UV_BIT);
  localparam logic [STAT_W-1:0] SEC_RST = STAT_W'(TONE_RST) << TONE_BIT;
  // Bits that carry a function; all others must read zero
  localparam logic [STAT_W-1:0] PRIM_USED = (STAT_W'(1) << OUT_OFF_BIT)
    | (STAT_W'(1) << THERMAL_BIT)
    | (STAT_W'(1) << UV_BIT);
  localparam logic [STAT_W-1:0] SEC_USED = STAT_W'(1) << TONE_BIT;

  // Two-stage synchronisers for the sense pins
  logic [2:0] sync1;
  logic [2:0] sync2;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
    end else begin
      sync1 <= {tone_sense_i, undervolt_i, overtemp_i};
      sync2 <= sync1;
    end
  end

  logic ot_s;
  logic uv_s;
  logic tone_s;
  assign ot_s = sync2[0];
  assign uv_s = sync2[1];
  assign tone_s = sync2[2];

  lfs_flags_s flags;
  lfs_flags_s next_flags;
  logic irq;
  logic next_irq;

  // Flag update: fault set wins over read-time clear
  always_comb begin
    next_flags = flags;
    next_irq = 1'b0;
    if (read_ninth_rise_i) begin
      next_flags.thermal = ot_s;
      next_flags.uv = uv_s;
    end
    if (ot_s) begin
      next_flags.thermal = 1'b1;
    end
    if (uv_s) begin
      next_flags.uv = 1'b1;
    end
    // Enabling write clears disabled only when no latched fault
    if (write_end_i && out_enable_bit_i && !next_flags.thermal && !next_flags.uv) begin
      next_flags.out_off = 1'b0;
    end else if (write_end_i && !out_enable_bit_i) begin
      next_flags.out_off = 1'b1;
    end
    if (ot_s || uv_s) begin
      next_flags.out_off = 1'b1;
    end
    next_flags.tone = tone_enable_i && tone_s;
    // Interrupt only on fault flag rising, never on disabled
    next_irq = (next_flags.thermal && !flags.thermal) || (next_flags.uv && !flags.uv);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags <= '{uv: UV_RST, thermal: THERMAL_RST, out_off: OUT_OFF_RST, tone: TONE_RST};
      irq <= 1'b0;
    end else begin
      flags <= next_flags;
      irq <= next_irq;
    end
  end

  // Registered status bytes, unused bits zero
  logic [STAT_W-1:0] next_prim;
  logic [STAT_W-1:0] next_sec;
  always_comb begin
    next_prim = '0;
    next_sec = '0;
    next_prim[OUT_OFF_BIT] = next_flags.out_off;
    next_prim[THERMAL_BIT] = next_flags.thermal;
    next_prim[UV_BIT] = next_flags.uv;
    next_sec[TONE_BIT] = next_flags.tone;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_status_primary_o <= PRIM_RST;
      tone_status_secondary_o <= SEC_RST;
      output_on_o <= ~OUT_OFF_RST;
      fault_irq_o <= 1'b0;
    end else begin
      fault_status_primary_o <= next_prim;
      tone_status_secondary_o <= next_sec;
      output_on_o <= !next_flags.out_off;
      fault_irq_o <= irq;
    end
  end

  // Assertions
  property p_thermal_set;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      ot_s |=> flags.thermal && flags.out_off;
  endproperty
  a_thermal_set: assert property (p_thermal_set) else $error("thermal not set");

  property p_thermal_clear;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      read_ninth_rise_i && !ot_s |=> !flags.thermal;
  endproperty
  a_thermal_clear: assert property (p_thermal_clear) else $error("thermal not cleared");

  property p_uv_set;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      uv_s |=> flags.uv && flags.out_off;
  endproperty
  a_uv_set: assert property (p_uv_set) else $error("uv not set");

  property p_uv_hold;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      flags.uv && !read_ninth_rise_i |=> flags.uv;
  endproperty
  a_uv_hold: assert property (p_uv_hold) else $error("uv dropped without read");

  property p_stay_off;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      flags.out_off && !write_end_i |=> flags.out_off;
  endproperty
  a_stay_off: assert property (p_stay_off) else $error("output on without write");

  property p_tone;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      1'b1 |=> flags.tone == ($past(tone_enable_i) && $past(tone_s));
  endproperty
  a_tone: assert property (p_tone) else $error("tone flag wrong");

  property p_tone_off;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      !tone_enable_i |=> tone_status_secondary_o[TONE_BIT] == 1'b0;
  endproperty
  a_tone_off: assert property (p_tone_off) else $error("tone flag not cleared");

  property p_unused;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      (tone_status_secondary_o & ~SEC_USED) == '0 && (fault_status_primary_o & ~PRIM_USED) == '0;
  endproperty
  a_unused: assert property (p_unused) else $error("unused bit set");

  // Irq registers in the same edge as the flags, so look at once
  property p_no_irq_off;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      $rose(flags.out_off) && $stable(flags.thermal) && $stable(flags.uv) |-> !irq;
  endproperty
  a_no_irq_off: assert property (p_no_irq_off) else $error("irq on disable");

  // Steps of a fault: seen, then output held off
  sequence s_fault_seen;
    ot_s || uv_s;
  endsequence

  sequence s_held_off;
    flags.out_off ##0 !output_on_o;
  endsequence

  property p_fault_off;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_fault_seen |=> s_held_off;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("output on during fault");

  // Overtemperature seen, then a cycle with no read
  sequence s_thermal_latch;
    ot_s ##1 !read_ninth_rise_i;
  endsequence

  property p_thermal_hold;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_thermal_latch |=> flags.thermal;
  endproperty
  a_thermal_hold: assert property (p_thermal_hold) else $error("thermal dropped early");

  // Enabling write refused while a fault flag is latched
  property p_refuse_enable;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      write_end_i && out_enable_bit_i && (flags.thermal || flags.uv) && !read_ninth_rise_i
      |=> flags.out_off;
  endproperty
  a_refuse_enable: assert property (p_refuse_enable) else $error("enable during fault");

  // Enabling write with no fault clears the disabled flag
  property p_enable_clear;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      write_end_i && out_enable_bit_i && !ot_s && !uv_s && !flags.thermal && !flags.uv
      |=> !flags.out_off;
  endproperty
  a_enable_clear: assert property (p_enable_clear) else $error("disabled not cleared");

  // Output enable always mirrors the disabled flag
  property p_out_follow;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      output_on_o == !flags.out_off;
  endproperty
  a_out_follow: assert property (p_out_follow) else $error("output state mismatch");

  // Tone enabled and present sets the tone flag
  property p_tone_on;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      tone_enable_i && tone_s |=> flags.tone;
  endproperty
  a_tone_on: assert property (p_tone_on) else $error("tone flag not set");

endmodule

// >>> logic/lfs_pkg.sv
package lfs_pkg;
  // Bit positions in the primary fault status byte
  localparam int unsigned OUT_OFF_BIT = 0;
  localparam int unsigned THERMAL_BIT = 6;
  localparam int unsigned UV_BIT = 7;
  // Bit position in the secondary tone status byte
  localparam int unsigned TONE_BIT = 2;
  // Status byte width
  localparam int unsigned STAT_W = 8;
  // Reset values: output disabled at power-on, no faults
  localparam logic THERMAL_RST = 1'b0;
  localparam logic UV_RST = 1'b0;
  localparam logic OUT_OFF_RST = 1'b1;
  localparam logic TONE_RST = 1'b0;
  // Flags travelling together
  typedef struct packed {
    logic uv;
    logic thermal;
    logic out_off;
    logic tone;
  } lfs_flags_s;
endpackage

// >>> dv/lfs_host_model.sv
`timescale 1ns/1ps
// Host side: ninth-clock read pulses and write ends
module lfs_host_model (
  // Clock
  input wire logic ref_clk_i,
  // Pulses toward the flag logic
  output logic read_ninth_rise_o = 1'h0,
  output logic write_end_o = 1'h0,
  output logic out_enable_bit_o = 1'h0
);
  // One pulse on the ninth clock rise of a data read
  task automatic rd();
    read_ninth_rise_o = 1'h1;
    @(posedge ref_clk_i);
    #2 read_ninth_rise_o = 1'h0;
  endtask
  // Write end with enable bit; only way to restore output
  task automatic wr(input logic en);
    out_enable_bit_o = en;
    write_end_o = 1'h1;
    @(posedge ref_clk_i);
    #2 write_end_o = 1'h0;
  endtask
endmodule

// >>> dv/lfs_status_flags_test.sv
`timescale 1ns/1ps
module lfs_status_flags_test;
  import lfs_pkg::*;
  logic ref_clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic overtemp_i = 1'h0;
  logic undervolt_i = 1'h0;
  logic tone_sense_i = 1'h0;
  logic tone_enable_i = 1'h0;
  logic read_ninth_rise_i, write_end_i, out_enable_bit_i, output_on_o, fault_irq_o;
  logic [STAT_W-1:0] fault_status_primary_o, tone_status_secondary_o;
  logic [16:0] exp_q[$];
  int fails = 0;
  int tests_run = 0;
  int irq_seen = 0;
  event noted;
  // Clock at 40 MHz
  always #12.5 ref_clk_i = ~ref_clk_i;
  lfs_status_flags u_lfs_status_flags (.ref_clk_i, .rst_n_i, .overtemp_i, .undervolt_i,
    .tone_sense_i, .read_ninth_rise_i, .write_end_i, .out_enable_bit_i, .tone_enable_i,
    .fault_status_primary_o, .tone_status_secondary_o, .output_on_o, .fault_irq_o);
  lfs_host_model u_lfs_host_model (.ref_clk_i, .read_ninth_rise_o(read_ninth_rise_i),
    .write_end_o(write_end_i), .out_enable_bit_o(out_enable_bit_i));
  // Compare and count
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Let sync and output stages settle, then note expectation
  task automatic note(input logic [7:0] p, input logic [7:0] s, input logic on);
    repeat (6) @(posedge ref_clk_i);
    #2 exp_q.push_back({p, s, on});
    ->noted;
  endtask
  // Monitor takes the oldest note and compares
  always @(noted) begin
    logic [16:0] e;
    e = exp_q.pop_front();
    chk("primary", fault_status_primary_o, e[16:9]);
    chk("secondary", tone_status_secondary_o, e[8:1]);
    chk("output_on", {7'h0, output_on_o}, {7'h0, e[0]});
  end
  // Count interrupt pulses away from the launching edge
  always @(negedge ref_clk_i) begin
    if (fault_irq_o === 1'b1) begin
      irq_seen++;
    end
  end
  // Verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    void'($urandom(32'hd448124b));
    repeat (4) @(posedge ref_clk_i);
    #2 rst_n_i = 1'h1;
    note(8'h01, 8'h00, 1'h0);
    u_lfs_host_model.wr(1'h1);
    note(8'h00, 8'h00, 1'h1);
    $display("test reset and enable done");
    for (int i = 0; i < 8; i++) begin
      tone_enable_i = i[0];
      tone_sense_i = 1'($urandom);
      note(8'h00, {5'h0, tone_enable_i & tone_sense_i, 2'h0}, 1'h1);
    end
    tone_enable_i = 1'h0;
    $display("test tone done");
    overtemp_i = 1'h1;
    note(8'h41, 8'h00, 1'h0);
    u_lfs_host_model.rd();
    overtemp_i = 1'h0;
    note(8'h41, 8'h00, 1'h0);
    u_lfs_host_model.rd();
    note(8'h01, 8'h00, 1'h0);
    u_lfs_host_model.wr(1'h1);
    note(8'h00, 8'h00, 1'h1);
    $display("test thermal done");
    undervolt_i = 1'h1;
    note(8'h81, 8'h00, 1'h0);
    undervolt_i = 1'h0;
    u_lfs_host_model.wr(1'h1);
    note(8'h81, 8'h00, 1'h0);
    u_lfs_host_model.rd();
    note(8'h01, 8'h00, 1'h0);
    u_lfs_host_model.wr(1'h1);
    note(8'h00, 8'h00, 1'h1);
    u_lfs_host_model.wr(1'h0);
    note(8'h01, 8'h00, 1'h0);
    chk("irq_count", 8'(irq_seen), 8'h02);
    $display("test undervoltage done");
    u_lfs_host_model.wr(1'h1);
    note(8'h00, 8'h00, 1'h1);
    @(posedge ref_clk_i);
    #2 rst_n_i = 1'h0;
    repeat (2) @(posedge ref_clk_i);
    #2 rst_n_i = 1'h1;
    note(8'h01, 8'h00, 1'h0);
    $display("test mid-run reset done");
    stop_test();
  end
  // Watchdog
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    fails++;
    stop_test();
  end
endmodule
